// *** include/gatrp_pkg.sv ***
package gatrp_pkg;
  localparam int NCH  = 4;
  localparam int SW   = 16;
  localparam int AW   = 8;
  localparam int SELW = 6;
  localparam int NEV  = 4;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_MODE     = 8'h00;
  localparam logic [AW-1:0] OFS_MSZ_LO   = 8'h04;
  localparam logic [AW-1:0] OFS_MSZ_HI   = 8'h08;
  localparam logic [AW-1:0] OFS_LOOPS    = 8'h0C;
  localparam logic [AW-1:0] OFS_CTRL     = 8'h10;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h14;
  localparam logic [AW-1:0] OFS_IRQ_ST   = 8'h18;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [AW-1:0] OFS_POS      = 8'h20;
  localparam logic [AW-1:0] OFS_IDLE0    = 8'h30;
  localparam logic [AW-1:0] OFS_CUST0    = 8'h40;

  // Operating modes
  localparam logic [31:0] MODE_MEM_GATE  = 32'h0000_0400;
  localparam logic [31:0] MODE_FIFO_GATE = 32'h0000_2000;

  // Idle level selector codes
  localparam logic [SELW-1:0] IDLE_NEG  = 6'h02;
  localparam logic [SELW-1:0] IDLE_POS  = 6'h04;
  localparam logic [SELW-1:0] IDLE_HOLD = 6'h08;
  localparam logic [SELW-1:0] IDLE_ZERO = 6'h10;
  localparam logic [SELW-1:0] IDLE_USER = 6'h20;

  // Control, status and event bit positions
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_GSRC   = 2;
  localparam int CTRL_EN_LSB = 4;
  localparam int STS_RUN     = 0;
  localparam int STS_GATE    = 1;
  localparam int STS_PLAY    = 2;
  localparam int EV_DONE     = 0;
  localparam int EV_UNDER    = 1;
  localparam int EV_GRISE    = 2;
  localparam int EV_GFALL    = 3;

  // Reset values and loop codes
  localparam logic [31:0]    RST_MODE    = MODE_MEM_GATE;
  localparam logic [63:0]    RST_MEMSIZE = 64'h0000_0000_0000_0020;
  localparam logic [31:0]    LOOP_INF    = 32'h0000_0000;
  localparam logic [31:0]    RST_LOOPS   = 32'h0000_0001;
  localparam logic [NCH-1:0] RST_CHEN    = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_PAUSE = 3'h2,
    ST_PLAY  = 3'h4
  } gatrp_state_t;
endpackage : gatrp_pkg

// *** include/gatrp_out_if.sv ***
`timescale 1ns/1ps
interface gatrp_out_if;
  import gatrp_pkg::*;
  logic                  smp_valid;
  logic [NCH*SW-1:0]     smp_data;
  logic [NCH-1:0]        ch_en;
  logic [NCH*SELW-1:0]   idle_sel;
  logic [NCH*SW-1:0]     custom;
  modport src (output smp_valid, smp_data, ch_en, idle_sel, custom);
  modport snk (input smp_valid, smp_data, ch_en, idle_sel, custom);
endinterface : gatrp_out_if

// *** hw/gatrp_gate_sync.sv ***
`timescale 1ns/1ps
module gatrp_gate_sync
  import gatrp_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Gate sources
  input  wire logic gate_pin,
  input  wire logic gate_int,
  input  wire logic src_ext,
  // Gate level and edges
  output logic      gate,
  output logic      rise,
  output logic      fall
);
  logic sync1_q;
  logic sync2_q;
  logic sel;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
    end else begin
      sync1_q <= gate_pin;
      sync2_q <= sync1_q;
    end
  end

  assign sel = src_ext ? sync2_q : gate_int;

  // Edges are aligned with the change of the level output
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate <= 1'h0;
      rise <= 1'h0;
      fall <= 1'h0;
    end else begin
      gate <= sel;
      rise <= sel & ~gate;
      fall <= ~sel & gate;
    end
  end
endmodule : gatrp_gate_sync

// *** hw/gatrp_idle_mux.sv ***
`timescale 1ns/1ps
module gatrp_idle_mux
  import gatrp_pkg::*;
#(
  parameter int DIG_BITS = 1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Samples and idle settings
  gatrp_out_if.snk         oif,
  // Converter words
  output logic [NCH*SW-1:0] dac_data
);
  // Digital lines sit above the two's complement analog field
  localparam logic [SW-1:0] LVL_ZERO = {SW{1'h0}};
  localparam logic [SW-1:0] LVL_NEG  =
    {{(SW-1){1'h0}}, 1'h1} << (SW - DIG_BITS - 1);
  localparam logic [SW-1:0] LVL_POS  = ~LVL_NEG;

  logic [SW-1:0] last_q [NCH];

  function automatic logic [SW-1:0] idle_lvl(
    input logic [SELW-1:0] s,
    input logic [SW-1:0]   last,
    input logic [SW-1:0]   cust
  );
    case (s)
      IDLE_NEG:  idle_lvl = LVL_NEG;   // [RQ4]
      IDLE_POS:  idle_lvl = LVL_POS;   // [RQ5]
      IDLE_HOLD: idle_lvl = last;      // [RQ6]
      IDLE_USER: idle_lvl = cust;      // [RQ7] [RQ8] [RQ9]
      default:   idle_lvl = LVL_ZERO;  // [RQ1] [RQ3]
    endcase
  endfunction : idle_lvl

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_data <= {(NCH*SW){1'h0}};
      for (int c = 0; c < NCH; c++) last_q[c] <= {SW{1'h0}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (oif.smp_valid && oif.ch_en[c]) begin
          dac_data[c*SW +: SW] <= oif.smp_data[c*SW +: SW];
          last_q[c]            <= oif.smp_data[c*SW +: SW];
        end else begin
          // Idle level stands until the next sample arrives
          dac_data[c*SW +: SW] <= idle_lvl(           // [RQ2] [RQ10]
            oif.idle_sel[c*SELW +: SELW], last_q[c],
            oif.custom[c*SW +: SW]);
        end
      end
    end
  end
endmodule : gatrp_idle_mux

// *** hw/gatrp_top.sv ***
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
// Operation
// RQ1: Default idle output after replay is the zero level.
// RQ2: Idle level stays until the next replayed sample appears.
// RQ3: Selector 16 gives converter zero, digital lines low.
// RQ4: Selector 2 gives most negative code, digital lines low.
// RQ5: Selector 4 gives most positive code, digital lines high.
// RQ6: Selector 8 holds the final sample including digital lines.
// RQ7: Selector 32 outputs a 16-bit custom word in sample format.
// RQ8: Custom word also sets each synchronous digital line.
// RQ9: Each of four channels has its own selector and custom word.
// RQ10: Channels not enabled always show their idle level.
// RQ11: Gated replay outputs samples only while the gate is true.
// RQ12: Gate end pauses replay; next gate continues where it stopped.
// RQ13: Memory mode, loops one: stop at count end, cutting the gate.
// RQ14: Memory mode, loops zero: wrap to start without gap, run on.
// RQ15: Mode code 400h selects memory gating, 2000h stream gating.
// RQ16: Memory mode replays exactly the programmed sample count.
// RQ17: Stream mode: zero runs until stop or underrun, else N gates.
// RQ18: Host keeps the sample stream flowing to avoid underrun.
// RQ19: Gate comes from the trigger engine with fixed start latency.
module gatrp_top
  import gatrp_pkg::*;
#(
  parameter int MEM_AW   = 32,
  parameter int DIG_BITS = 1
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,

  // APB register port
  input  wire logic [AW-1:0]     paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,

  // Gate sources
  input  wire logic              gate_pin,
  input  wire logic              gate_int,

  // Sample memory read port, one cycle latency
  output logic                   mem_rd,
  output logic [MEM_AW-1:0]      mem_addr,
  input  wire logic [NCH*SW-1:0] mem_rdata,

  // Host sample stream
  input  wire logic [NCH*SW-1:0] s_data,
  input  wire logic              s_valid,
  output logic                   s_ready,

  // Converter side and status
  output logic [NCH*SW-1:0]      dac_data,
  output logic                   replay_active,
  output logic                   irq
);

  // Configuration
  logic [31:0]     mode_q;
  logic [63:0]     memsize_q;
  logic [31:0]     loops_q;
  logic            gsrc_q;
  logic [NCH-1:0]  chen_q;
  logic [SELW-1:0] idle_sel_q [NCH];
  logic [SW-1:0]   custom_q   [NCH];
  logic [NEV-1:0]  irq_st_q;
  logic [NEV-1:0]  irq_mask_q;

  // Replay engine
  gatrp_state_t    state_q;
  logic            fifo_q;
  logic [63:0]     ptr_q;
  logic [31:0]     gates_q;
  logic            rd_v_q;
  logic            f_v_q;
  logic [NCH*SW-1:0] f_data_q;

  // Bus decode
  logic            wr_en;
  logic            setup;
  logic            hit;
  logic [31:0]     rdata;
  logic            start;
  logic            stop;
  logic            mode_ok;

  // Gate and engine terms
  logic            gate;
  logic            g_rise;
  logic            g_fall;
  logic            run;
  logic            play_now;
  logic            std_rd;
  logic            fifo_take;
  logic            underrun;
  logic            last_smp;
  logic            done_std;
  logic            gate_end;
  logic            done_fifo;
  logic            done;
  logic [NEV-1:0]  ev;

  gatrp_out_if oif ();

  function automatic logic is_idle(input logic [AW-1:0] a);
    is_idle = (a[AW-1:4] == OFS_IDLE0[AW-1:4]) && (a[1:0] == 2'h0);
  endfunction : is_idle

  function automatic logic is_cust(input logic [AW-1:0] a);
    is_cust = (a[AW-1:4] == OFS_CUST0[AW-1:4]) && (a[1:0] == 2'h0);
  endfunction : is_cust

  // APB: zero wait states, every access completes in its first access cycle
  assign pready  = 1'h1;
  assign wr_en   = psel & penable & pwrite;
  assign setup   = psel & ~penable;
  assign start   = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_START];
  assign stop    = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_STOP];
  assign mode_ok = (mode_q == MODE_MEM_GATE) ||
                   (mode_q == MODE_FIFO_GATE);  // [RQ15]

  always_comb begin
    hit   = 1'h1;
    rdata = 32'h0000_0000;
    case (paddr)
      OFS_MODE:     rdata = mode_q;
      OFS_MSZ_LO:   rdata = memsize_q[31:0];
      OFS_MSZ_HI:   rdata = memsize_q[63:32];
      OFS_LOOPS:    rdata = loops_q;
      OFS_CTRL: begin
        rdata[CTRL_GSRC]            = gsrc_q;
        rdata[CTRL_EN_LSB +: NCH]   = chen_q;
      end
      OFS_STATUS: begin
        rdata[STS_RUN]  = run;
        rdata[STS_GATE] = gate;
        rdata[STS_PLAY] = play_now;
      end
      OFS_IRQ_ST:   rdata[NEV-1:0] = irq_st_q;
      OFS_IRQ_MASK: rdata[NEV-1:0] = irq_mask_q;
      OFS_POS:      rdata = ptr_q[31:0];
      default: begin
        if (is_idle(paddr)) begin
          rdata[SELW-1:0] = idle_sel_q[paddr[3:2]];
        end else if (is_cust(paddr)) begin
          rdata[SW-1:0] = custom_q[paddr[3:2]];
        end else begin
          hit = 1'h0;
        end
      end
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'h0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata;
      pslverr <= ~hit;
    end
  end

  // Mode, count, gate source and channel enable settings
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q    <= RST_MODE;
      memsize_q <= RST_MEMSIZE;
      loops_q   <= RST_LOOPS;
      gsrc_q    <= 1'h1;
      chen_q    <= RST_CHEN;
    end else if (wr_en) begin
      case (paddr)
        OFS_MODE:   mode_q            <= pwdata;
        OFS_MSZ_LO: memsize_q[31:0]   <= pwdata;
        OFS_MSZ_HI: memsize_q[63:32]  <= pwdata;
        OFS_LOOPS:  loops_q           <= pwdata;
        OFS_CTRL: begin
          gsrc_q <= pwdata[CTRL_GSRC];
          chen_q <= pwdata[CTRL_EN_LSB +: NCH];
        end
        default: ;
      endcase
    end
  end

  // Per-channel idle selection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NCH; c++) begin
        idle_sel_q[c] <= IDLE_ZERO;  // [RQ1]
        custom_q[c]   <= {SW{1'h0}};
      end
    end else if (wr_en) begin
      if (is_idle(paddr)) begin
        idle_sel_q[paddr[3:2]] <= pwdata[SELW-1:0];  // [RQ9]
      end
      if (is_cust(paddr)) begin
        custom_q[paddr[3:2]] <= pwdata[SW-1:0];  // [RQ9]
      end
    end
  end

  // Gate source: pin through a synchroniser or the trigger engine
  gatrp_gate_sync u_gate (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .gate_pin (gate_pin),
    .gate_int (gate_int),
    .src_ext  (gsrc_q),
    .gate     (gate),
    .rise     (g_rise),
    .fall     (g_fall)
  );  // [RQ19]

  assign run       = (state_q != ST_IDLE);
  assign play_now  = (state_q == ST_PLAY) && gate;  // [RQ11]
  assign std_rd    = play_now && !fifo_q;
  assign fifo_take = play_now && fifo_q && s_valid;
  // An empty stream while the gate is open ends the replay
  assign underrun  = play_now && fifo_q && !s_valid;  // [RQ17] [RQ18]
  assign last_smp  = (ptr_q + 64'h1) >= memsize_q;  // [RQ16]
  assign done_std  = std_rd && last_smp && (loops_q != LOOP_INF);  // [RQ13]
  assign gate_end  = (state_q == ST_PLAY) && g_fall;
  assign done_fifo = gate_end && fifo_q && (loops_q != LOOP_INF) &&
                     ((gates_q + 32'h1) == loops_q);  // [RQ17]
  assign done      = done_std || done_fifo;

  // Replay state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      fifo_q  <= 1'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start && mode_ok) begin
            state_q <= ST_PAUSE;
            fifo_q  <= (mode_q == MODE_FIFO_GATE);  // [RQ15]
          end
        end
        ST_PAUSE: begin
          if (stop) begin
            state_q <= ST_IDLE;
          end else if (gate) begin
            state_q <= ST_PLAY;  // [RQ12]
          end
        end
        ST_PLAY: begin
          if (stop || done || underrun) begin
            state_q <= ST_IDLE;
          end else if (!gate) begin
            state_q <= ST_PAUSE;  // [RQ12]
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory position survives pauses so replay resumes in place
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= 64'h0;
    end else if (state_q == ST_IDLE && start) begin
      ptr_q <= 64'h0;
    end else if (std_rd) begin
      ptr_q <= last_smp ? 64'h0 : ptr_q + 64'h1;  // [RQ12] [RQ14]
    end
  end

  // Gate count for the stream form
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gates_q <= 32'h0;
    end else if (state_q == ST_IDLE && start) begin
      gates_q <= 32'h0;
    end else if (gate_end && fifo_q) begin
      gates_q <= gates_q + 32'h1;  // [RQ17]
    end
  end

  assign mem_rd   = std_rd;
  assign mem_addr = ptr_q[MEM_AW-1:0];
  assign s_ready  = play_now && fifo_q;

  // Sample pipeline toward the output stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_v_q   <= 1'h0;
      f_v_q    <= 1'h0;
      f_data_q <= {(NCH*SW){1'h0}};
    end else begin
      rd_v_q <= std_rd;
      f_v_q  <= fifo_take;
      if (fifo_take) begin
        f_data_q <= s_data;
      end
    end
  end

  assign oif.smp_valid = rd_v_q || f_v_q;
  assign oif.smp_data  = rd_v_q ? mem_rdata : f_data_q;
  assign oif.ch_en     = chen_q;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      oif.idle_sel[c*SELW +: SELW] = idle_sel_q[c];
      oif.custom[c*SW +: SW]       = custom_q[c];
    end
  end

  gatrp_idle_mux #(
    .DIG_BITS (DIG_BITS)
  ) u_mux (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .oif      (oif),
    .dac_data (dac_data)
  );

  assign replay_active = run;

  // Interrupt events
  always_comb begin
    ev           = {NEV{1'h0}};
    ev[EV_DONE]  = done;
    ev[EV_UNDER] = underrun;
    ev[EV_GRISE] = run && g_rise;
    ev[EV_GFALL] = run && g_fall;
  end

  // Events win over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_st_q   <= {NEV{1'h0}};
      irq_mask_q <= {NEV{1'h0}};
    end else begin
      if (wr_en && paddr == OFS_IRQ_ST) begin
        irq_st_q <= (irq_st_q & ~pwdata[NEV-1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      if (wr_en && paddr == OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[NEV-1:0];
      end
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);
endmodule : gatrp_top

// *** test/gatrp_asserts.sv ***
`timescale 1ns/1ps
module gatrp_asserts
  import gatrp_pkg::*;
#(
  parameter int MEM_AW = 32
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              resetn,
  // Register port
  input wire logic [AW-1:0]     paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Gate and samples
  input wire logic              gate_int,
  input wire logic              mem_rd,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [NCH*SW-1:0] mem_rdata,
  input wire logic [NCH*SW-1:0] s_data,
  input wire logic              s_valid,
  input wire logic              s_ready,
  // Converter side
  input wire logic [NCH*SW-1:0] dac_data,
  input wire logic              replay_active
);
  logic [3:0]  en_q;
  logic        src_q;
  logic [31:0] msz_q;
  logic [31:0] mode_q;
  wire         wacc = psel && penable && pwrite;
  wire         hs   = mem_rd || (s_valid && s_ready);
  wire         good = mode_q == MODE_MEM_GATE || mode_q == MODE_FIFO_GATE;
  wire         strt = wacc && paddr == OFS_CTRL && pwdata[0] && !pwdata[1];
  wire [63:0]  lm   = {{16{en_q[3]}}, {16{en_q[2]}},
                       {16{en_q[1]}}, {16{en_q[0]}}};

  // Shadow of the settings that decide what the outputs may do
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_q   <= RST_CHEN;
      src_q  <= 1'b1;
      msz_q  <= RST_MEMSIZE[31:0];
      mode_q <= RST_MODE;
    end else if (wacc) begin
      if (paddr == OFS_CTRL) en_q <= pwdata[7:4];
      if (paddr == OFS_CTRL) src_q <= pwdata[CTRL_GSRC];
      if (paddr == OFS_MSZ_LO) msz_q <= pwdata;
      if (paddr == OFS_MODE) mode_q <= pwdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  mem_data_a: assert property ($past(mem_rd, 2) |->
    ((dac_data ^ $past(mem_rdata)) & lm) == 64'h0)
    else $error("converter word differs from memory sample");
  stream_data_a: assert property ($past(s_valid && s_ready, 2) |->
    ((dac_data ^ $past(s_data, 2)) & lm) == 64'h0)
    else $error("converter word differs from streamed sample");
  gate_only_a: assert property ((mem_rd || s_ready) && !src_q |->
    $past(gate_int) || $past(gate_int, 2))
    else $error("sample taken without gate");
  idle_quiet_a: assert property (!replay_active |->
    !mem_rd && !s_ready)
    else $error("sample taken while idle");
  addr_step_a: assert property (mem_rd && $past(mem_rd) |->
    mem_addr == ($past(mem_addr) + 1 == msz_q ? 0 : $past(mem_addr) + 1))
    else $error("memory address not consecutive");
  addr_bound_a: assert property (mem_rd |-> mem_addr < msz_q)
    else $error("memory read beyond sample count");
  dac_hold_a: assert property (!$past(hs, 2) && !$past(hs, 3) &&
    !$past(psel) && !$past(psel, 2) && !$past(psel, 3) && !$past(psel, 4)
    |-> $stable(dac_data))
    else $error("idle level moved without cause");
  gate_lat_a: assert property ($past(gate_int, 2) &&
    $past(gate_int) && !$past(src_q, 2) && !$past(src_q) &&
    $past(replay_active) && replay_active |-> mem_rd || s_ready)
    else $error("no replay two cycles after the gate opened");
  start_ok_a: assert property (strt && good |=> replay_active)
    else $error("start with valid mode ignored");
  start_bad_a: assert property (strt && !good && !replay_active
    |=> !replay_active)
    else $error("start with invalid mode accepted");
  unmapped_a: assert property (psel && penable && paddr == 8'hFC |->
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  cover property (mem_rd && mem_addr == 0 && $past(mem_rd));
  cover property ($fell(replay_active));
  cover property (s_valid && s_ready);
endmodule : gatrp_asserts

bind gatrp_top gatrp_asserts #(.MEM_AW(MEM_AW)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .gate_int(gate_int), .mem_rd(mem_rd),
  .mem_addr(mem_addr), .mem_rdata(mem_rdata), .s_data(s_data),
  .s_valid(s_valid), .s_ready(s_ready), .dac_data(dac_data),
  .replay_active(replay_active)
);

// *** test/gatrp_host_model.sv ***
`timescale 1ns/1ps
module gatrp_host_model
  import gatrp_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // Bench control
  input wire logic               stall,
  // Sample memory
  input wire logic               mem_rd,
  input wire logic [31:0]        mem_addr,
  output logic [NCH*SW-1:0]      mem_rdata,
  // Sample stream
  output logic [NCH*SW-1:0]      s_data,
  output logic                   s_valid,
  input wire logic               s_ready
);
  logic [11:0] cnt_q;

  // Stale memory data is inverted each cycle so a sample one cycle late never looks right
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      mem_rdata <= '0;
    else if (mem_rd)
      for (int c = 0; c < NCH; c++)
        mem_rdata[16*c+:16] <= {2'(c), 2'b01, mem_addr[11:0]};
    else
      mem_rdata <= ~mem_rdata;
  end

  // Host keeps words flowing unless the bench orders a stall
  assign s_valid = resetn && !stall;

  always_comb
    for (int c = 0; c < NCH; c++)
      s_data[16*c+:16] = {2'(c), 2'b10, cnt_q} ^ {16{!s_valid}};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      cnt_q <= '0;
    else if (s_valid && s_ready)
      cnt_q <= cnt_q + 12'h001;
  end
endmodule : gatrp_host_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import gatrp_pkg::*;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic        gate_pin, gate_int, stall, mem_rd, s_valid, s_ready;
  logic        replay_active, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, mem_addr, nexp, msz;
  logic [63:0] mem_rdata, s_data, dac_data;
  logic [5:0]  sel[4];
  logic [15:0] cus[4];
  logic [15:0] lst[4] = '{4{16'h0}};
  logic [5:0]  codes[5] = '{IDLE_ZERO, IDLE_NEG, IDLE_POS, IDLE_HOLD,
                            IDLE_USER};
  int          mismatches, check_count, nrd, ng;

  gatrp_top uut (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_pin(gate_pin),
    .gate_int(gate_int), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .s_data(s_data), .s_valid(s_valid),
    .s_ready(s_ready), .dac_data(dac_data), .replay_active(replay_active),
    .irq(irq));
  gatrp_host_model host (
    .clk_sys(clk_sys), .resetn(resetn), .stall(stall), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .s_data(s_data),
    .s_valid(s_valid), .s_ready(s_ready));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Memory reads must resume where the last gate left off
  always @(posedge clk_sys) begin
    if (resetn && mem_rd) begin
      `CHK("mem_addr", nexp, mem_addr)
      nrd++;
      nexp = (nexp + 1 == msz) ? 0 : nexp + 1;
    end
  end

  function automatic logic [15:0] lvl(input int c);
    case (sel[c])
      IDLE_NEG:  return 16'h4000;
      IDLE_POS:  return 16'hBFFF;
      IDLE_HOLD: return lst[c];
      IDLE_USER: return cus[c];
      default:   return 16'h0000;
    endcase
  endfunction : lvl

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input int k);
    for (int c = 0; c < NCH; c++) begin
      sel[c] = codes[(k + c) % 5];
      cus[c] = 16'($urandom);
      apb(1'b1, OFS_CUST0 + 8'(4 * c), {16'h0, cus[c]});
      apb(1'b1, OFS_IDLE0 + 8'(4 * c), {26'h0, sel[c]});
    end
  endtask : cfg

  task automatic chk_idle(input logic [3:0] on);
    for (int c = 0; c < NCH; c++)
      if (!on[c])
        `CHK("idle", lvl(c), dac_data[16*c+:16])
  endtask : chk_idle

  // Random gate pulses; disabled lanes are checked mid-burst
  task automatic gates(input int n, input logic pin, input logic [3:0] on);
    ng = 0;
    // The start write lands on the edge that the bus task returns on
    @(posedge clk_sys);
    while (ng < n && replay_active === 1'b1) begin
      gate_pin <= pin;
      gate_int <= !pin;
      repeat (3 + $urandom % 10) @(posedge clk_sys);
      chk_idle(on);
      gate_pin <= 1'b0;
      gate_int <= 1'b0;
      ng++;
      // Engine pauses, or goes idle after the last counted stream gate, two edges after the gate drops
      repeat (3 + $urandom % 5) @(posedge clk_sys);
    end
  endtask : gates

  task automatic wait_idle();
    for (int i = 0; i < 40 && replay_active !== 1'b0; i++)
      @(posedge clk_sys);
  endtask : wait_idle

  task automatic tend(input string n);
    $display("test %s finished", n);
  endtask : tend

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  initial begin
    {resetn, psel, penable, pwrite, gate_pin, gate_int, stall} = '0;
    paddr = '0;
    pwdata = '0;
    nexp = '0;
    msz = 32'd32;
    void'($urandom(32'hC69A681E));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    `CHK("dac_rst", 64'h0, dac_data)
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK("mode", MODE_MEM_GATE, r)
    apb(1'b0, OFS_IDLE0, 32'h0);
    `CHK("idle0", 32'h10, r)
    apb(1'b0, 8'hFC, 32'h0);
    `CHK("slverr", 1'b1, pslverr)
    tend("registers");
    for (int k = 0; k < 5; k++) begin
      cfg(k);
      repeat (3) @(posedge clk_sys);
      chk_idle(4'h0);
    end
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_CTRL, 32'hF1);
    @(posedge clk_sys);
    `CHK("bad_start", 1'b0, replay_active)
    tend("idle levels");
    apb(1'b1, OFS_MODE, MODE_MEM_GATE);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    cfg(3);
    nrd = 0;
    apb(1'b1, OFS_CTRL, 32'h71);
    gates(40, 1'b0, 4'h7);
    `CHK("reads", 32, nrd)
    for (int c = 0; c < 3; c++)
      lst[c] = {2'(c), 2'b01, 12'h01F};
    chk_idle(4'h0);
    `CHK("irq", 1'b1, irq)
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    `CHK("done", 1'b1, r[EV_DONE])
    apb(1'b1, OFS_IRQ_ST, 32'hF);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    `CHK("irq_clr", 1'b0, irq)
    tend("memory once");
    apb(1'b1, OFS_LOOPS, 32'h0);
    nrd = 0;
    nexp = 0;
    apb(1'b1, OFS_CTRL, 32'hF5);
    gate_pin <= 1'b1;
    repeat (90) @(posedge clk_sys);
    `CHK("wrap", 1'b1, replay_active && nrd > 64)
    gate_pin <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'hF2);
    wait_idle();
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    `CHK("rise", 1'b1, r[EV_GRISE])
    `CHK("masked", 1'b0, irq)
    tend("memory loop");
    apb(1'b1, OFS_MODE, MODE_FIFO_GATE);
    apb(1'b1, OFS_LOOPS, 32'h2);
    apb(1'b1, OFS_CTRL, 32'hF1);
    gates(6, 1'b0, 4'hF);
    `CHK("gates", 2, ng)
    apb(1'b1, OFS_LOOPS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'hF1);
    gate_int <= 1'b1;
    repeat (10) @(posedge clk_sys);
    `CHK("fifo_run", 1'b1, replay_active)
    stall <= 1'b1;
    wait_idle();
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    `CHK("underrun", 1'b1, r[EV_UNDER])
    tend("stream");
    stop_test();
  end
endmodule : testbench
